/* design/pki_pkg.sv */
/*
  Package for the port and key input interrupt block: register indices,
  field positions, selector codes, reset values and system numbering.
  Assumes a byte-wide register file reached over a 32-bit classic Wishbone bus,
  with each register index occupying one aligned word (byte address = 4 * index).
*/
package pki_pkg;

  // Register index width and indices (byte address is four times the index)
  localparam int IDX_W = 19;
  localparam logic [IDX_W-1:0] IDX_PORT01_PRIORITY = 19'h40260;
  localparam logic [IDX_W-1:0] IDX_PORT23_PRIORITY = 19'h40261;
  localparam logic [IDX_W-1:0] IDX_KEY_PRIORITY = 19'h40262;
  localparam logic [IDX_W-1:0] IDX_PORT45_PRIORITY = 19'h4026C;
  localparam logic [IDX_W-1:0] IDX_PORT67_PRIORITY = 19'h4026D;
  localparam logic [IDX_W-1:0] IDX_KEY_PORT03_IRQ_ENABLE = 19'h40270;
  localparam logic [IDX_W-1:0] IDX_PORT47_IRQ_ENABLE = 19'h40277;
  localparam logic [IDX_W-1:0] IDX_KEY_PORT03_IRQ_FLAGS = 19'h40280;
  localparam logic [IDX_W-1:0] IDX_PORT47_IRQ_FLAGS = 19'h40287;
  localparam logic [IDX_W-1:0] IDX_PORT03_PIN_SELECT = 19'h402C6;
  localparam logic [IDX_W-1:0] IDX_PORT47_PIN_SELECT = 19'h402C7;
  localparam logic [IDX_W-1:0] IDX_PORT_POLARITY_SELECT = 19'h402C8;
  localparam logic [IDX_W-1:0] IDX_PORT_TRIGGER_SELECT = 19'h402C9;
  localparam logic [IDX_W-1:0] IDX_KEY_GROUP_SELECT = 19'h402CA;
  localparam logic [IDX_W-1:0] IDX_KEY0_COMPARE_PATTERN = 19'h402CC;
  localparam logic [IDX_W-1:0] IDX_KEY1_COMPARE_PATTERN = 19'h402CD;
  localparam logic [IDX_W-1:0] IDX_KEY0_INPUT_MASK = 19'h402CE;
  localparam logic [IDX_W-1:0] IDX_KEY1_INPUT_MASK = 19'h402CF;
  localparam logic [IDX_W-1:0] IDX_FLAG_CLEAR_METHOD = 19'h402DF;

  // System counts and numbering: ports 0..7, key 0 is 8, key 1 is 9
  localparam int N_PORT = 8;
  localparam int N_SYS = 10;
  localparam int SYS_KEY0 = 8;
  localparam int SYS_KEY1 = 9;
  localparam int KEY0_W = 5;
  localparam int KEY1_W = 4;
  localparam int LVL_W = 3;
  localparam int SYS_ID_W = 4;

  // Field positions
  localparam int PRI_EVEN_LSB = 0;
  localparam int PRI_ODD_LSB = 4;
  localparam int SEL_W = 2;
  localparam int SEL_KEY0_LSB = 0;
  localparam int SEL_KEY1_LSB = 2;
  localparam int EN_PORT_LO_LSB = 0;
  localparam int EN_KEY_LSB = 4;
  localparam int EN_PORT_HI_LSB = 2;

  // Pin selector codes, shared by port and key systems
  localparam logic [1:0] SEL_PORT2 = 2'h3;
  localparam logic [1:0] SEL_PORT0 = 2'h2;
  localparam logic [1:0] SEL_ALT = 2'h1;
  localparam logic [1:0] SEL_KEY6 = 2'h0;

  // Reset values and settling time of the input synchroniser
  localparam logic [7:0] CFG_COLD_VALUE = 8'h00;
  localparam logic FLAG_METHOD_RESET = 1'b1;
  localparam logic [1:0] ARM_CYCLES = 2'h3;

endpackage

/* design/pki_top.sv */
/*
  Port-input and key-input interrupt logic: eight single-pin port systems,
  two key-pattern systems, byte registers on a classic Wishbone slave and a
  priority arbiter that presents one request to the CPU interrupt logic.
  Assumes all pins and the CPU level inputs are synchronous to i_sys_clk
  (pins are still double-flopped), and that i_cold_start is valid while
  i_srst is high.
*/
// What this block does
// - 2-bit code picks each port system's pin
// - Pin selectors two bits per system, two registers
// - Input settings clear on cold start, kept on hot
// - Polarity 1 high/rising, 0 low/falling
// - Trigger 1 edge, 0 level
// - Key systems select pin group by code
// - Key fires on match-to-mismatch change
// - Compare 1 falling, 0 rising, reads back
// - Key compare/mask in low bits, rest reserved
// - Mask 1 enables input, 0 ignores it
// - Three-bit priority level per system
// - Even system bits 2:0, odd bits 6:4
// - Priority levels not initialised by reset
// - Enable bits gate CPU request
// - Enables cleared on every reset
// - Factor flags report occurred interrupt factors
// - Flag sets regardless of enable, priority
// - Reset-only method: write 1 clears flag
// - Request needs flag, enable, top priority, level
`timescale 1ns/10ps
`default_nettype none

module pki_top
  import pki_pkg::*;
#(
  parameter int ADR_W = 21
)
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_cold_start,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Input pins
  input wire logic [7:0] i_port2,
  input wire logic [7:0] i_port0,
  input wire logic [2:0] i_port3_hi,
  input wire logic [4:0] i_key5,
  input wire logic [7:0] i_key6,
  // CPU interrupt interface
  input wire logic i_cpu_ie,
  input wire logic [LVL_W-1:0] i_cpu_level,
  input wire logic i_higher_pending,
  output logic o_irq_req,
  output logic [LVL_W-1:0] o_irq_level,
  output logic [SYS_ID_W-1:0] o_irq_system
);

  localparam int PIN_W = 32;

  // Configuration state
  logic [2*N_PORT-1:0] port_pin_selector;
  logic [N_PORT-1:0] port_polarity_bit;
  logic [N_PORT-1:0] port_trigger_type_bit;
  logic [7:0] key_group_selector;
  logic [KEY0_W-1:0] key0_compare_bit;
  logic [KEY1_W-1:0] key1_compare_bit;
  logic [KEY0_W-1:0] key0_mask_bit;
  logic [KEY1_W-1:0] key1_mask_bit;
  logic [LVL_W-1:0] priority_level [N_SYS];
  logic [N_SYS-1:0] irq_enable;
  logic [N_SYS-1:0] factor_flag;
  logic flag_clear_method;

  // Bus decode
  logic [IDX_W-1:0] acc_idx;
  logic acc_req;
  logic wr_stb;
  logic [7:0] wr_byte;
  logic [7:0] next_rd_byte;

  // Input path
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic [7:0] s_port2;
  logic [7:0] s_port0;
  logic [7:0] s_alt;
  logic [7:0] s_key6;
  logic [1:0] arm_cnt;
  logic armed;
  logic [N_PORT-1:0] port_cur;
  logic [N_PORT-1:0] port_prev;
  logic [KEY0_W-1:0] key0_in;
  logic [KEY1_W-1:0] key1_in;
  logic key0_match;
  logic key1_match;
  logic key0_prev_match;
  logic key1_prev_match;
  logic [N_SYS-1:0] factor_event;

  // Arbitration
  logic next_found;
  logic [LVL_W-1:0] next_best_lvl;
  logic [SYS_ID_W-1:0] next_best_sys;

  assign acc_idx = i_wb_adr[ADR_W-1:2];
  assign acc_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr_stb = acc_req & i_wb_we & i_wb_sel[0];
  assign wr_byte = i_wb_dat[7:0];

  // Wishbone answer: one-cycle ack, unmapped indices read zero
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end
    else
    begin
      o_wb_ack <= acc_req;
      o_wb_dat <= {24'h00_0000, next_rd_byte};
    end
  end

  // Read mux, reserved bits read zero
  always_comb
  begin
    next_rd_byte = 8'h00;
    unique case (acc_idx)
      IDX_PORT01_PRIORITY:
        next_rd_byte = {1'b0, priority_level[1], 1'b0, priority_level[0]};
      IDX_PORT23_PRIORITY:
        next_rd_byte = {1'b0, priority_level[3], 1'b0, priority_level[2]};
      IDX_KEY_PRIORITY:
        next_rd_byte = {1'b0, priority_level[SYS_KEY1], 1'b0, priority_level[SYS_KEY0]};
      IDX_PORT45_PRIORITY:
        next_rd_byte = {1'b0, priority_level[5], 1'b0, priority_level[4]};
      IDX_PORT67_PRIORITY:
        next_rd_byte = {1'b0, priority_level[7], 1'b0, priority_level[6]};
      IDX_KEY_PORT03_IRQ_ENABLE:
        next_rd_byte = {2'h0, irq_enable[SYS_KEY1:SYS_KEY0], irq_enable[3:0]};
      IDX_PORT47_IRQ_ENABLE:
        next_rd_byte = {2'h0, irq_enable[7:4], 2'h0};
      IDX_KEY_PORT03_IRQ_FLAGS:
        next_rd_byte = {2'h0, factor_flag[SYS_KEY1:SYS_KEY0], factor_flag[3:0]};
      IDX_PORT47_IRQ_FLAGS:
        next_rd_byte = {2'h0, factor_flag[7:4], 2'h0};
      IDX_PORT03_PIN_SELECT:
        next_rd_byte = port_pin_selector[7:0];
      IDX_PORT47_PIN_SELECT:
        next_rd_byte = port_pin_selector[15:8];
      IDX_PORT_POLARITY_SELECT:
        next_rd_byte = port_polarity_bit;
      IDX_PORT_TRIGGER_SELECT:
        next_rd_byte = port_trigger_type_bit;
      IDX_KEY_GROUP_SELECT:
        next_rd_byte = {4'h0, key_group_selector[3:0]};
      IDX_KEY0_COMPARE_PATTERN:
        next_rd_byte = {3'h0, key0_compare_bit};
      IDX_KEY1_COMPARE_PATTERN:
        next_rd_byte = {4'h0, key1_compare_bit};
      IDX_KEY0_INPUT_MASK:
        next_rd_byte = {3'h0, key0_mask_bit};
      IDX_KEY1_INPUT_MASK:
        next_rd_byte = {4'h0, key1_mask_bit};
      IDX_FLAG_CLEAR_METHOD:
        next_rd_byte = {7'h00, flag_clear_method};
      default:
        next_rd_byte = 8'h00;
    endcase
  end

  // Input configuration, cleared only on cold start
  // cold clears, hot keeps
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      if (i_cold_start)
      begin
        port_pin_selector <= {CFG_COLD_VALUE, CFG_COLD_VALUE};
        port_polarity_bit <= CFG_COLD_VALUE;
        port_trigger_type_bit <= CFG_COLD_VALUE;
        key_group_selector <= CFG_COLD_VALUE;
        key0_compare_bit <= CFG_COLD_VALUE[KEY0_W-1:0];
        key1_compare_bit <= CFG_COLD_VALUE[KEY1_W-1:0];
        key0_mask_bit <= CFG_COLD_VALUE[KEY0_W-1:0];
        key1_mask_bit <= CFG_COLD_VALUE[KEY1_W-1:0];
      end
    end
    else if (wr_stb)
    begin
      unique case (acc_idx)
        IDX_PORT03_PIN_SELECT: port_pin_selector[7:0] <= wr_byte;
        IDX_PORT47_PIN_SELECT: port_pin_selector[15:8] <= wr_byte;
        IDX_PORT_POLARITY_SELECT: port_polarity_bit <= wr_byte;
        IDX_PORT_TRIGGER_SELECT: port_trigger_type_bit <= wr_byte;
        IDX_KEY_GROUP_SELECT: key_group_selector <= {4'h0, wr_byte[3:0]};
        IDX_KEY0_COMPARE_PATTERN: key0_compare_bit <= wr_byte[KEY0_W-1:0];
        IDX_KEY1_COMPARE_PATTERN: key1_compare_bit <= wr_byte[KEY1_W-1:0];
        IDX_KEY0_INPUT_MASK: key0_mask_bit <= wr_byte[KEY0_W-1:0];
        IDX_KEY1_INPUT_MASK: key1_mask_bit <= wr_byte[KEY1_W-1:0];
        default: ;
      endcase
    end
  end

  // Priority levels carry no reset value
  // no reset here
  always_ff @(posedge i_sys_clk)
  begin
    if (wr_stb)
    begin
      unique case (acc_idx)
        IDX_PORT01_PRIORITY:
        begin
          priority_level[0] <= wr_byte[PRI_EVEN_LSB +: LVL_W];
          priority_level[1] <= wr_byte[PRI_ODD_LSB +: LVL_W];
        end
        IDX_PORT23_PRIORITY:
        begin
          priority_level[2] <= wr_byte[PRI_EVEN_LSB +: LVL_W];
          priority_level[3] <= wr_byte[PRI_ODD_LSB +: LVL_W];
        end
        IDX_KEY_PRIORITY:
        begin
          priority_level[SYS_KEY0] <= wr_byte[PRI_EVEN_LSB +: LVL_W];
          priority_level[SYS_KEY1] <= wr_byte[PRI_ODD_LSB +: LVL_W];
        end
        IDX_PORT45_PRIORITY:
        begin
          priority_level[4] <= wr_byte[PRI_EVEN_LSB +: LVL_W];
          priority_level[5] <= wr_byte[PRI_ODD_LSB +: LVL_W];
        end
        IDX_PORT67_PRIORITY:
        begin
          priority_level[6] <= wr_byte[PRI_EVEN_LSB +: LVL_W];
          priority_level[7] <= wr_byte[PRI_ODD_LSB +: LVL_W];
        end
        default: ;
      endcase
    end
  end

  // Enable bits and flag-clear method
  // enables cleared
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      irq_enable <= '0;
      flag_clear_method <= FLAG_METHOD_RESET;
    end
    else if (wr_stb)
    begin
      unique case (acc_idx)
        IDX_KEY_PORT03_IRQ_ENABLE:
        begin
          irq_enable[3:0] <= wr_byte[EN_PORT_LO_LSB +: 4];
          irq_enable[SYS_KEY1:SYS_KEY0] <= wr_byte[EN_KEY_LSB +: 2];
        end
        IDX_PORT47_IRQ_ENABLE: irq_enable[7:4] <= wr_byte[EN_PORT_HI_LSB +: 4];
        IDX_FLAG_CLEAR_METHOD: flag_clear_method <= wr_byte[0];
        default: ;
      endcase
    end
  end

  // Two-flop synchroniser on every pin, plus a settle counter after reset
  // pin synchroniser
  always_ff @(posedge i_sys_clk)
  begin
    pin_meta <= {i_port2, i_port0, i_port3_hi, i_key5, i_key6};
    pin_sync <= pin_meta;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      arm_cnt <= 2'h0;
    else if (arm_cnt != ARM_CYCLES)
      arm_cnt <= arm_cnt + 2'h1;
  end

  assign armed = (arm_cnt == ARM_CYCLES);
  assign s_port2 = pin_sync[31:24];
  assign s_port0 = pin_sync[23:16];
  assign s_alt = pin_sync[15:8];
  assign s_key6 = pin_sync[7:0];

  // Port systems: pin select, polarity, edge or level
  genvar gi;
  generate
    for (gi = 0; gi < N_PORT; gi++)
    begin : g_port
      always_comb
      begin
        unique case (port_pin_selector[gi*SEL_W +: SEL_W])
          SEL_PORT2: port_cur[gi] = s_port2[gi];
          SEL_PORT0: port_cur[gi] = s_port0[gi];
          SEL_ALT: port_cur[gi] = s_alt[gi];
          SEL_KEY6: port_cur[gi] = s_key6[gi];
        endcase
      end

      always_comb
      begin
        if (port_trigger_type_bit[gi])
          factor_event[gi] = (port_cur[gi] != port_prev[gi]) &&
            (port_cur[gi] == port_polarity_bit[gi]);
        else
          factor_event[gi] = (port_cur[gi] == port_polarity_bit[gi]);
      end
    end
  endgenerate

  // Key group selection
  // key group decode
  always_comb
  begin
    unique case (key_group_selector[SEL_KEY0_LSB +: SEL_W])
      SEL_PORT2: key0_in = s_port2[KEY0_W-1:0];
      SEL_PORT0: key0_in = s_port0[KEY0_W-1:0];
      SEL_ALT: key0_in = s_key6[KEY0_W-1:0];
      SEL_KEY6: key0_in = s_alt[KEY0_W-1:0];
    endcase
    unique case (key_group_selector[SEL_KEY1_LSB +: SEL_W])
      SEL_PORT2: key1_in = s_port2[7:4];
      SEL_PORT0: key1_in = s_port0[7:4];
      SEL_ALT: key1_in = s_key6[7:4];
      SEL_KEY6: key1_in = s_key6[3:0];
    endcase
  end

  // Match when every unmasked input equals its compare bit
  // masked inputs ignored
  assign key0_match = ((key0_in ^ key0_compare_bit) & key0_mask_bit) == '0;
  assign key1_match = ((key1_in ^ key1_compare_bit) & key1_mask_bit) == '0;
  always_comb
  begin
    factor_event[SYS_KEY0] = key0_prev_match & ~key0_match;
    factor_event[SYS_KEY1] = key1_prev_match & ~key1_match;
  end

  // Previous samples for edge and change detection
  // compare with previous
  always_ff @(posedge i_sys_clk)
  begin
    port_prev <= port_cur;
    key0_prev_match <= key0_match;
    key1_prev_match <= key1_match;
  end

  // Factor flags: set wins over software clear
  // set independent of enable
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      factor_flag <= '0;
    else
    begin
      for (int i = 0; i < N_SYS; i++)
      begin
        if (armed && factor_event[i])
          factor_flag[i] <= 1'b1;
        else if (wr_stb && (acc_idx == IDX_KEY_PORT03_IRQ_FLAGS) && (i < N_PORT / 2))
          factor_flag[i] <= flag_clear_method ? (factor_flag[i] & ~wr_byte[i]) : wr_byte[i];
        else if (wr_stb && (acc_idx == IDX_KEY_PORT03_IRQ_FLAGS) && (i >= SYS_KEY0))
          factor_flag[i] <= flag_clear_method ?
            (factor_flag[i] & ~wr_byte[EN_KEY_LSB + i - SYS_KEY0]) :
            wr_byte[EN_KEY_LSB + i - SYS_KEY0];
        else if (wr_stb && (acc_idx == IDX_PORT47_IRQ_FLAGS) &&
          (i >= N_PORT / 2) && (i < N_PORT))
          factor_flag[i] <= flag_clear_method ?
            (factor_flag[i] & ~wr_byte[EN_PORT_HI_LSB + i - N_PORT / 2]) :
            wr_byte[EN_PORT_HI_LSB + i - N_PORT / 2];
      end
    end
  end

  // Highest-level pending and enabled system, lowest number wins a tie
  always_comb
  begin
    next_found = 1'b0;
    next_best_lvl = '0;
    next_best_sys = '0;
    for (int i = 0; i < N_SYS; i++)
    begin
      if (factor_flag[i] && irq_enable[i] &&
        (!next_found || (priority_level[i] > next_best_lvl)))
      begin
        next_found = 1'b1;
        next_best_lvl = priority_level[i];
        next_best_sys = SYS_ID_W'(i);
      end
    end
  end

  // Request to the CPU
  // request conditions
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      o_irq_req <= 1'b0;
      o_irq_level <= '0;
      o_irq_system <= '0;
    end
    else
    begin
      o_irq_req <= next_found && i_cpu_ie && !i_higher_pending &&
        (next_best_lvl > i_cpu_level);
      o_irq_level <= next_found ? next_best_lvl : '0;
      o_irq_system <= next_best_sys;
    end
  end

endmodule

`default_nettype wire

/* test/pki_pins.sv */
/*
  Pin model: the board keys and input pins seen by the block.
  Assumes the bench calls set_pin; every change lands just after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none

module pki_pins
(
  // Clock
  input wire logic i_sys_clk,
  // Pins
  output var logic [7:0] o_port2,
  output var logic [7:0] o_port0,
  output var logic [2:0] o_port3_hi,
  output var logic [4:0] o_key5,
  output var logic [7:0] o_key6
);
  // All pins start low
  initial
  begin
    o_port2 = 8'h00;
    o_port0 = 8'h00;
    o_port3_hi = 3'h0;
    o_key5 = 5'h00;
    o_key6 = 8'h00;
  end

  // Drive one pin: 0 port 2, 1 port 0, 2 key 5, 3 key 6, 4 port 3
  task automatic set_pin(input int w, input int b, input logic v);
    @(posedge i_sys_clk);
    case (w)
      0: o_port2[b] <= v;
      1: o_port0[b] <= v;
      2: o_key5[b] <= v;
      3: o_key6[b] <= v;
      default: o_port3_hi[b] <= v;
    endcase
  endtask
endmodule

`default_nettype wire

/* test/pki_checker.sv */
/*
  Checker of bus and request timing at the ports of pki_top.
  Assumes it is bound to pki_top and sees its ports only.
*/
`timescale 1ns/10ps
`default_nettype none

module pki_checker
  import pki_pkg::*;
#(
  parameter int ADR_W = 21
)
(
  // Watched ports
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ADR_W-1:0] i_wb_adr,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_cpu_ie,
  input wire logic [LVL_W-1:0] i_cpu_level,
  input wire logic i_higher_pending,
  input wire logic o_irq_req,
  input wire logic [LVL_W-1:0] o_irq_level,
  input wire logic [SYS_ID_W-1:0] o_irq_system
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  // Bus answer timing
  a_ack_after_req: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (o_wb_ack |-> $past(i_wb_stb) && !$past(o_wb_ack))
    else $error("ack without request");
  a_dat_upper_zero: assert property (o_wb_dat[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_rsvd_zero: assert property (
    i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack && i_wb_adr[ADR_W-1:2] == IDX_KEY0_COMPARE_PATTERN
    |=> o_wb_dat[7:5] == 3'h0) else $error("reserved compare bits read nonzero");

  // Request gating
  a_req_gated: assert property (
    o_irq_req |-> $past(i_cpu_ie) && !$past(i_higher_pending))
    else $error("request while blocked");
  a_req_level_gt: assert property (o_irq_req |-> o_irq_level > $past(i_cpu_level))
    else $error("request level not above cpu level");
  a_sys_range: assert property (o_irq_req |-> o_irq_system < 4'hA)
    else $error("request from unknown system");
endmodule

bind pki_top pki_checker #(.ADR_W(ADR_W)) i_chk (
  .i_sys_clk(i_sys_clk),
  .i_srst(i_srst),
  .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we),
  .i_wb_adr(i_wb_adr),
  .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack),
  .i_cpu_ie(i_cpu_ie),
  .i_cpu_level(i_cpu_level),
  .i_higher_pending(i_higher_pending),
  .o_irq_req(o_irq_req),
  .o_irq_level(o_irq_level),
  .o_irq_system(o_irq_system)
);

`default_nettype wire

/* test/tb_pki_top.sv */
/*
  Self-checking bench for pki_top: register model, pin events, requests.
  Assumes pki_pins drives the pins and pki_checker is bound to the design.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_pki_top;
  import pki_pkg::*;

  // Stimulus and observed signals
  logic i_sys_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_cold_start = 1'b1;
  logic i_wb_cyc = 1'b0;
  logic i_wb_stb = 1'b0;
  logic i_wb_we = 1'b0;
  logic [20:0] i_wb_adr = 21'h0;
  logic [31:0] i_wb_dat = 32'h0;
  logic i_cpu_ie = 1'b0;
  logic [2:0] i_cpu_level = 3'h0;
  logic i_higher_pending = 1'b0;
  logic [31:0] o_wb_dat;
  logic o_wb_ack;
  logic o_irq_req;
  logic [2:0] o_irq_level;
  logic [3:0] o_irq_system;
  logic [7:0] p2, p0, k6;
  logic [2:0] p3;
  logic [4:0] k5;
  int err_total = 0;
  int tests_run = 0;
  localparam logic [IDX_W-1:0] FL = IDX_KEY_PORT03_IRQ_FLAGS;
  localparam logic [IDX_W-1:0] RI [16] = '{IDX_PORT01_PRIORITY, IDX_PORT23_PRIORITY,
    IDX_KEY_PRIORITY, IDX_PORT45_PRIORITY, IDX_PORT67_PRIORITY, IDX_KEY_PORT03_IRQ_ENABLE,
    IDX_PORT47_IRQ_ENABLE, IDX_PORT03_PIN_SELECT, IDX_PORT47_PIN_SELECT,
    IDX_PORT_POLARITY_SELECT, IDX_PORT_TRIGGER_SELECT, IDX_KEY_GROUP_SELECT,
    IDX_KEY0_COMPARE_PATTERN, IDX_KEY1_COMPARE_PATTERN, IDX_KEY0_INPUT_MASK,
    IDX_KEY1_INPUT_MASK};
  localparam logic [7:0] RM [16] = '{8'h77, 8'h77, 8'h77, 8'h77, 8'h77, 8'h3F, 8'h3C,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h1F, 8'h0F, 8'h1F, 8'h0F};
  logic [7:0] mdl [16];

  // Clock, design and pins
  always #2.5 i_sys_clk = ~i_sys_clk;
  pki_pins u_pins (.i_sys_clk(i_sys_clk), .o_port2(p2), .o_port0(p0), .o_port3_hi(p3),
    .o_key5(k5), .o_key6(k6));
  pki_top i_dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_cold_start(i_cold_start),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
    .i_wb_sel(4'hF), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_port2(p2), .i_port0(p0), .i_port3_hi(p3), .i_key5(k5), .i_key6(k6),
    .i_cpu_ie(i_cpu_ie), .i_cpu_level(i_cpu_level), .i_higher_pending(i_higher_pending),
    .o_irq_req(o_irq_req), .o_irq_level(o_irq_level), .o_irq_system(o_irq_system));

  // Verdict and end of run
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Compare one value
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One classic Wishbone cycle, held until ack
  task automatic bus(input logic [IDX_W-1:0] idx, input logic w, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= {idx, 2'b00};
    i_wb_dat <= {24'h0, d};
    do
    begin
      @(posedge i_sys_clk);
      n++;
    end
    while (o_wb_ack !== 1'b1 && n < 20);
    if (o_wb_ack !== 1'b1)
      err_total++;
    q = o_wb_dat[7:0];
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask

  // Write, read-and-compare, pin change with settle time
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(idx, 1'b1, d, q);
  endtask
  task automatic rc(input logic [IDX_W-1:0] idx, input logic [7:0] e, input string nm);
    logic [7:0] q;
    bus(idx, 1'b0, 8'h00, q);
    chk(nm, {24'h0, e}, {24'h0, q});
  endtask
  task automatic pin(input int w, input int b, input logic v);
    u_pins.set_pin(w, b, v);
    repeat (6) @(posedge i_sys_clk);
  endtask
  task automatic rst(input logic cold);
    @(posedge i_sys_clk);
    i_cold_start <= cold;
    i_srst <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
  endtask

  // Watchdog
  initial
  begin
    #100000;
    err_total++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    void'($urandom(32'h840F));
    rst(1'b1);
    for (int k = 5; k < 16; k++)
      rc(RI[k], 8'h00, "cold value");
    for (int k = 0; k < 16; k++)
    begin
      mdl[k] = 8'($urandom()) & RM[k];
      wr(RI[k], 8'($urandom()) | mdl[k]);
      mdl[k] = 8'(i_wb_dat) & RM[k];
    end
    for (int k = 0; k < 16; k++)
      rc(RI[k], mdl[k], "readback");
    rc(19'h40263, 8'h00, "unmapped");
    $display("register test done");
    rst(1'b0);
    for (int k = 5; k < 16; k++)
      rc(RI[k], (k < 7) ? 8'h00 : mdl[k], "hot value");
    rst(1'b1);
    for (int k = 7; k < 16; k++)
      rc(RI[k], 8'h00, "cold clear");
    $display("reset test done");
    wr(IDX_PORT_POLARITY_SELECT, 8'hFF);
    wr(IDX_PORT_TRIGGER_SELECT, 8'hFF);
    for (int c = 0; c < 4; c++)
    begin
      wr(IDX_PORT03_PIN_SELECT, 8'(c << 6));
      wr(FL, 8'h3F);
      pin(3 - c, 3, 1'b1);
      rc(FL, 8'h08, "rising flag");
      wr(FL, 8'h00);
      rc(FL, 8'h08, "write0 keeps");
      wr(FL, 8'h08);
      pin(3 - c, 3, 1'b0);
      rc(FL, 8'h00, "fall ignored");
    end
    wr(IDX_PORT_POLARITY_SELECT, 8'hF7);
    pin(0, 3, 1'b1);
    rc(FL, 8'h00, "rise ignored");
    pin(0, 3, 1'b0);
    rc(FL, 8'h08, "falling flag");
    $display("edge test done");
    wr(IDX_PORT23_PRIORITY, 8'h50);
    wr(IDX_KEY_PORT03_IRQ_ENABLE, 8'h08);
    i_cpu_ie <= 1'b1;
    i_cpu_level <= 3'h2;
    repeat (3) @(posedge i_sys_clk);
    chk("req", 32'h1, {31'h0, o_irq_req});
    chk("level", 32'h5, {29'h0, o_irq_level});
    chk("system", 32'h3, {28'h0, o_irq_system});
    i_higher_pending <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    chk("req blocked", 32'h0, {31'h0, o_irq_req});
    i_higher_pending <= 1'b0;
    i_cpu_level <= 3'h5;
    repeat (3) @(posedge i_sys_clk);
    chk("req at cpu level", 32'h0, {31'h0, o_irq_req});
    i_cpu_level <= 3'h2;
    wr(IDX_KEY_PORT03_IRQ_ENABLE, 8'h00);
    repeat (2) @(posedge i_sys_clk);
    chk("req disabled", 32'h0, {31'h0, o_irq_req});
    $display("request test done");
    wr(IDX_PORT_TRIGGER_SELECT, 8'hF7);
    wr(FL, 8'h3F);
    rc(FL, 8'h08, "level holds");
    wr(IDX_PORT_POLARITY_SELECT, 8'hFF);
    wr(FL, 8'h3F);
    rc(FL, 8'h00, "level off");
    wr(IDX_KEY0_INPUT_MASK, 8'h01);
    wr(FL, 8'h3F);
    pin(2, 1, 1'b1);
    rc(FL, 8'h00, "masked key");
    pin(2, 0, 1'b1);
    rc(FL, 8'h10, "key mismatch");
    wr(FL, 8'h3F);
    pin(2, 0, 1'b0);
    rc(FL, 8'h00, "key rematch");
    wr(IDX_KEY0_COMPARE_PATTERN, 8'h01);
    pin(2, 0, 1'b1);
    wr(FL, 8'h3F);
    pin(2, 0, 1'b0);
    rc(FL, 8'h10, "key falling");
    wr(IDX_KEY_GROUP_SELECT, 8'h0C);
    wr(IDX_KEY1_INPUT_MASK, 8'h01);
    wr(FL, 8'h3F);
    pin(0, 4, 1'b1);
    rc(FL, 8'h20, "key1 group");
    rc(IDX_FLAG_CLEAR_METHOD, 8'h01, "clear method");
    wr(IDX_FLAG_CLEAR_METHOD, 8'h00);
    wr(FL, 8'h10);
    rc(FL, 8'h10, "rw method");
    wr(IDX_PORT47_IRQ_FLAGS, 8'h3C);
    rc(IDX_PORT47_IRQ_FLAGS, 8'h3C, "high flags");
    wr(IDX_FLAG_CLEAR_METHOD, 8'h01);
    wr(IDX_PORT47_IRQ_FLAGS, 8'h3C);
    rc(IDX_PORT47_IRQ_FLAGS, 8'h00, "high flags clear");
    $display("key test done");
    finish_test();
  end
endmodule

`default_nettype wire
